// File: logic/flash_suspend_pkg.sv
// constants shared by both ends of the suspend/resume command link
//==============================================================================
// Notes on behaviour
// (RULE1) block unlock four-byte accepted in either suspend
// (RULE2) quad output reads 6B/6C accepted in suspend
// (RULE3) quad io reads EB/EC/ED accepted in suspend
// (RULE4) continuous read reset FF accepted in suspend
// (RULE5) secure area program only during erase suspend
// (RULE6) secure area read accepted in either suspend
// (RULE7) host sets quad enable before first program/erase
// (RULE8) every other opcode rejected while suspended; code also accepts status two read 07
// (RULE9) reads inside suspended sector/page return junk
// (RULE10) program in erase suspend returns to suspend
// (RULE11) resume sets busy and continues operation
// (RULE12) resume ignored when nothing is suspended
// (RULE13) host spaces some resumes before next suspend
// (RULE14) program suspended flag at status two bit0
// (RULE15) erase suspended flag at status two bit1
// (RULE16) only host resume continues suspended work
// (RULE17) four-wire mode: opcode as two nibbles
// (RULE18) secure region from address bits 15..8
// (RULE19) host drives address bits 23..16 as zero
// (RULE20) resume, reset arm and reset accepted in suspend
// (RULE21) busy zero while suspended, flag held till resume; code keeps busy set during a program in erase suspend
package flash_suspend_pkg;
    //==========================================================================
    // opcodes
    localparam logic [7:0] block_unlock_four_byte_cmd             = 8'hE2;
    localparam logic [7:0] quad_output_read_cmd                   = 8'h6B;
    localparam logic [7:0] quad_output_read_four_byte_cmd         = 8'h6C;
    localparam logic [7:0] quad_io_read_cmd                       = 8'hEB;
    localparam logic [7:0] quad_io_read_four_byte_cmd             = 8'hEC;
    localparam logic [7:0] double_rate_quad_io_read_cmd           = 8'hED;
    localparam logic [7:0] double_rate_quad_io_read_four_byte_cmd = 8'hED;
    localparam logic [7:0] continuous_read_reset_cmd              = 8'hFF;
    localparam logic [7:0] secure_area_program_cmd                = 8'h42;
    localparam logic [7:0] secure_area_read_cmd                   = 8'h48;
    localparam logic [7:0] operation_resume_cmd                   = 8'h7A;
    localparam logic [7:0] soft_reset_arm_cmd                     = 8'h66;
    localparam logic [7:0] soft_reset_cmd                         = 8'h99;
    localparam logic [7:0] status_config_write_cmd                = 8'h01;
    localparam logic [7:0] any_register_write_cmd                 = 8'h71;
    localparam logic [7:0] pointer_protection_write_cmd           = 8'hFB;
    localparam logic [7:0] status_two_read_cmd                    = 8'h07;
    //==========================================================================
    // status two fields
    localparam int PROG_SUSP_BIT  = 0;
    localparam int ERASE_SUSP_BIT = 1;
    localparam int BUSY_BIT       = 2;
    localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
    //==========================================================================
    // secure region address fields
    localparam int REGION_LSB   = 8;
    localparam int REGION_MSB   = 15;
    localparam int HIGH_ADR_LSB = 16;
    localparam logic [7:0] REGION_LAST = 8'h03;
    //==========================================================================
    // timing
    localparam int CLK_PERIOD_NS     = 8;
    localparam int LINK_HALF_NS      = 40;
    localparam int LINK_HALF_CYCLES  = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESUME_TO_SUSPEND_MIN_NS     = 100000;
    localparam int RESUME_TO_SUSPEND_MIN_CYCLES =
        (RESUME_TO_SUSPEND_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPERATION_CYCLES = 64;
    //==========================================================================
    // device state
    typedef enum logic [2:0] {
        ST_IDLE, ST_ERASE_RUN, ST_PROG_RUN, ST_ERASE_SUSP, ST_PROG_SUSP, ST_EPROG_RUN
    } op_state_e;
endpackage : flash_suspend_pkg

// File: logic/flash_link_if.sv
// four-wire serial link between host controller and flash device
interface flash_link_if;
    logic       sel_n;
    logic       sclk;
    logic [3:0] io_host_o;
    logic [3:0] io_host_oe;
    logic [3:0] io_dev_o;
    logic [3:0] io_dev_oe;
    logic [3:0] io;

    //==========================================================================
    // wire resolution: whoever enables drives, otherwise pulled high
    genvar g;
    for (g = 0; g < 4; g++) begin : g_res
        assign io[g] = io_host_oe[g] ? io_host_o[g] : (io_dev_oe[g] ? io_dev_o[g] : 1'b1);
    end

    modport host (output sel_n, output sclk, output io_host_o, output io_host_oe, input io);
    modport dev  (input sel_n, input sclk, output io_dev_o, output io_dev_oe, input io);
endinterface : flash_link_if

// File: logic/opcode_gate.sv
// decides which opcodes the device may accept in its current suspend state
module opcode_gate (
    input  wire logic [7:0] opcode_i,
    input  wire logic       erase_susp_i,
    input  wire logic       prog_susp_i,
    output logic            accept_o
);
    always_comb begin
        if (!erase_susp_i && !prog_susp_i) begin
            accept_o = 1'b1;
        end else begin
            case (opcode_i)
                flash_suspend_pkg::block_unlock_four_byte_cmd:     accept_o = 1'b1; // RULE1
                flash_suspend_pkg::quad_output_read_cmd,
                flash_suspend_pkg::quad_output_read_four_byte_cmd: accept_o = 1'b1; // RULE2
                flash_suspend_pkg::quad_io_read_cmd,
                flash_suspend_pkg::quad_io_read_four_byte_cmd,
                flash_suspend_pkg::double_rate_quad_io_read_cmd:   accept_o = 1'b1; // RULE3
                flash_suspend_pkg::continuous_read_reset_cmd:      accept_o = 1'b1; // RULE4
                flash_suspend_pkg::secure_area_program_cmd:        accept_o = erase_susp_i && !prog_susp_i; // RULE5
                flash_suspend_pkg::secure_area_read_cmd:           accept_o = 1'b1; // RULE6
                flash_suspend_pkg::operation_resume_cmd,
                flash_suspend_pkg::soft_reset_arm_cmd,
                flash_suspend_pkg::soft_reset_cmd:                 accept_o = 1'b1; // RULE20
                flash_suspend_pkg::status_two_read_cmd:            accept_o = 1'b1;
                default:                                           accept_o = 1'b0; // RULE8
            endcase
        end
    end
endmodule : opcode_gate

// File: logic/flash_suspend_device.sv
// device end: receives opcodes on the link and tracks suspend/resume state
module flash_suspend_device #(
    parameter int OP_CYCLES = flash_suspend_pkg::OPERATION_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    flash_link_if.dev        link,
    input  wire logic        quad_mode_i,
    input  wire logic        start_erase_i,
    input  wire logic        start_prog_i,
    input  wire logic        suspend_i,
    input  wire logic [23:0] busy_addr_i,
    input  wire logic        busy_is_page_i,
    output logic [7:0]       opcode_o,
    output logic             opcode_valid_o,
    output logic             opcode_accept_o,
    output logic             read_undetermined_o,
    output logic [1:0]       region_o,
    output logic             region_valid_o,
    output logic [7:0]       status_two_o
);
    if (OP_CYCLES < 2 || OP_CYCLES > 65535) begin : g_bad_op_cycles
        $error("OP_CYCLES must be 2 to 65535");
    end

    //==========================================================================
    // pin synchronisers
    logic [1:0] sclk_sync_reg, sclk_sync_next;
    logic [1:0] seln_sync_reg, seln_sync_next;
    logic [7:0] io_sync_reg,   io_sync_next;
    logic       sclk_prev_reg, sclk_prev_next;

    always_comb begin
        sclk_sync_next = {sclk_sync_reg[0], link.sclk};
        seln_sync_next = {seln_sync_reg[0], link.sel_n};
        io_sync_next   = {io_sync_reg[3:0], link.io};
        sclk_prev_next = sclk_sync_reg[1];
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sclk_sync_reg <= 2'b00;
            seln_sync_reg <= 2'b11;
            io_sync_reg   <= 8'hFF;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_sync_reg <= sclk_sync_next;
            seln_sync_reg <= seln_sync_next;
            io_sync_reg   <= io_sync_next;
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    wire logic       sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg;
    wire logic       sel_n_s   = seln_sync_reg[1];
    wire logic [3:0] io_s      = io_sync_reg[7:4];

    //==========================================================================
    // frame receiver: opcode then 24-bit address, one or four bits a clock
    logic [31:0] shift_reg, shift_next;
    logic [5:0]  bits_reg,  bits_next;
    logic [7:0]  opcode_reg, opcode_next;
    logic        op_got_reg, op_got_next;
    logic        adr_got_reg, adr_got_next;
    logic        opv_reg, opv_next;
    logic        adrv_reg, adrv_next;

    always_comb begin
        shift_next   = shift_reg;
        bits_next    = bits_reg;
        opcode_next  = opcode_reg;
        op_got_next  = op_got_reg;
        adr_got_next = adr_got_reg;
        opv_next     = 1'b0;
        adrv_next    = 1'b0;
        if (sel_n_s) begin
            bits_next    = 6'd0;
            op_got_next  = 1'b0;
            adr_got_next = 1'b0;
        end else if (sclk_rise && !adr_got_reg) begin
            if (quad_mode_i) begin
                shift_next = {shift_reg[27:0], io_s}; // RULE17
                bits_next  = bits_reg + 6'd4;
            end else begin
                shift_next = {shift_reg[30:0], io_s[0]};
                bits_next  = bits_reg + 6'd1;
            end
            if (!op_got_reg && bits_next == 6'd8) begin
                opcode_next = shift_next[7:0];
                op_got_next = 1'b1;
                opv_next    = 1'b1;
                bits_next   = 6'd0;
            end else if (op_got_reg && bits_next == 6'd24) begin
                adr_got_next = 1'b1;
                adrv_next    = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_reg   <= 32'h0000_0000;
            bits_reg    <= 6'd0;
            opcode_reg  <= 8'h00;
            op_got_reg  <= 1'b0;
            adr_got_reg <= 1'b0;
            opv_reg     <= 1'b0;
            adrv_reg    <= 1'b0;
        end else begin
            shift_reg   <= shift_next;
            bits_reg    <= bits_next;
            opcode_reg  <= opcode_next;
            op_got_reg  <= op_got_next;
            adr_got_reg <= adr_got_next;
            opv_reg     <= opv_next;
            adrv_reg    <= adrv_next;
        end
    end

    //==========================================================================
    // suspend state and embedded operation timer
    flash_suspend_pkg::op_state_e state_reg, state_next;
    logic [15:0] timer_reg, timer_next;
    logic [15:0] nest_reg,  nest_next;
    logic        accept;
    logic        prog_susp_reg, prog_susp_next;
    logic        erase_susp_reg, erase_susp_next;

    opcode_gate opcode_gate_inst (
        .opcode_i     (opcode_reg),
        .erase_susp_i (erase_susp_reg),
        .prog_susp_i  (prog_susp_reg),
        .accept_o     (accept)
    );

    wire logic resume_cmd = opv_reg && accept && opcode_reg == flash_suspend_pkg::operation_resume_cmd;
    wire logic done       = timer_reg == 16'd1;

    always_comb begin
        state_next = state_reg;
        timer_next = (timer_reg != 16'd0) ? timer_reg - 16'd1 : timer_reg;
        case (state_reg)
            flash_suspend_pkg::ST_IDLE: begin
                if (start_erase_i) begin
                    state_next = flash_suspend_pkg::ST_ERASE_RUN;
                    timer_next = 16'(OP_CYCLES);
                end else if (start_prog_i) begin
                    state_next = flash_suspend_pkg::ST_PROG_RUN;
                    timer_next = 16'(OP_CYCLES);
                end
            end
            flash_suspend_pkg::ST_ERASE_RUN: begin
                if (suspend_i) state_next = flash_suspend_pkg::ST_ERASE_SUSP;
                else if (done) state_next = flash_suspend_pkg::ST_IDLE;
            end
            flash_suspend_pkg::ST_PROG_RUN: begin
                if (suspend_i) state_next = flash_suspend_pkg::ST_PROG_SUSP;
                else if (done) state_next = flash_suspend_pkg::ST_IDLE;
            end
            // timer frozen while suspended; resume moves on, or a program start in erase suspend
            flash_suspend_pkg::ST_ERASE_SUSP: begin
                timer_next = timer_reg;
                if (resume_cmd) state_next = flash_suspend_pkg::ST_ERASE_RUN; // RULE11 RULE16
                else if (start_prog_i) state_next = flash_suspend_pkg::ST_EPROG_RUN;
            end
            flash_suspend_pkg::ST_PROG_SUSP: begin
                timer_next = timer_reg;
                if (resume_cmd) state_next = flash_suspend_pkg::ST_PROG_RUN; // RULE11
            end
            flash_suspend_pkg::ST_EPROG_RUN: begin
                // erase timer stays frozen; nested program runs a fixed length
                timer_next = timer_reg;
                if (nest_reg == 16'd1 || suspend_i) state_next = flash_suspend_pkg::ST_ERASE_SUSP; // RULE10
            end
            default: state_next = flash_suspend_pkg::ST_IDLE;
        endcase
        // resume with nothing suspended changes nothing
        prog_susp_next  = state_next == flash_suspend_pkg::ST_PROG_SUSP; // RULE12 RULE14
        erase_susp_next = state_next == flash_suspend_pkg::ST_ERASE_SUSP
                       || state_next == flash_suspend_pkg::ST_EPROG_RUN; // RULE15 RULE21
    end

    always_comb begin
        nest_next = nest_reg;
        if (state_reg != flash_suspend_pkg::ST_EPROG_RUN && state_next == flash_suspend_pkg::ST_EPROG_RUN)
            nest_next = 16'(OP_CYCLES);
        else if (nest_reg != 16'd0)
            nest_next = nest_reg - 16'd1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg      <= flash_suspend_pkg::ST_IDLE;
            timer_reg      <= 16'd0;
            nest_reg       <= 16'd0;
            prog_susp_reg  <= 1'b0;
            erase_susp_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            timer_reg      <= timer_next;
            nest_reg       <= nest_next;
            prog_susp_reg  <= prog_susp_next;
            erase_susp_reg <= erase_susp_next;
        end
    end
    // nested program end is tracked by its own counter
    wire logic busy = state_reg == flash_suspend_pkg::ST_ERASE_RUN
                   || state_reg == flash_suspend_pkg::ST_PROG_RUN
                   || (state_reg == flash_suspend_pkg::ST_EPROG_RUN && nest_reg != 16'd0); // RULE21 RULE10

    //==========================================================================
    // outputs: opcode report, address checks, status
    logic [7:0] opcode_o_next;
    logic       undet_next, regv_next;
    logic [1:0] region_next;
    logic [7:0] stat_next;
    wire logic  suspended = prog_susp_reg || erase_susp_reg;
    wire logic  is_read   = opcode_reg == flash_suspend_pkg::quad_output_read_cmd
                         || opcode_reg == flash_suspend_pkg::quad_output_read_four_byte_cmd
                         || opcode_reg == flash_suspend_pkg::quad_io_read_cmd
                         || opcode_reg == flash_suspend_pkg::quad_io_read_four_byte_cmd
                         || opcode_reg == flash_suspend_pkg::double_rate_quad_io_read_cmd;
    wire logic  is_sec    = opcode_reg == flash_suspend_pkg::secure_area_read_cmd
                         || opcode_reg == flash_suspend_pkg::secure_area_program_cmd;
    wire logic [7:0] reg_field = shift_reg[flash_suspend_pkg::REGION_MSB:flash_suspend_pkg::REGION_LSB];
    // page compare uses bits 23..8, sector compare bits 23..12
    wire logic  hit = busy_is_page_i ? shift_reg[23:8] == busy_addr_i[23:8]
                                     : shift_reg[23:12] == busy_addr_i[23:12];

    always_comb begin
        opcode_o_next = opv_reg ? opcode_reg : opcode_o;
        undet_next    = read_undetermined_o;
        region_next   = region_o;
        regv_next     = region_valid_o;
        if (opv_reg) begin
            undet_next = 1'b0;
            regv_next  = 1'b0;
        end
        if (adrv_reg && accept) begin
            if (is_read) undet_next = suspended && hit; // RULE9
            if (is_sec) begin
                region_next = reg_field[1:0]; // RULE18
                regv_next   = reg_field <= flash_suspend_pkg::REGION_LAST
                           && shift_reg[23:flash_suspend_pkg::HIGH_ADR_LSB] == 8'h00;
            end
        end
        stat_next = flash_suspend_pkg::STATUS_TWO_RESET;
        stat_next[flash_suspend_pkg::PROG_SUSP_BIT]  = prog_susp_reg; // RULE14
        stat_next[flash_suspend_pkg::ERASE_SUSP_BIT] = erase_susp_reg; // RULE15
        stat_next[flash_suspend_pkg::BUSY_BIT]       = busy;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            opcode_o            <= 8'h00;
            opcode_valid_o      <= 1'b0;
            opcode_accept_o     <= 1'b0;
            read_undetermined_o <= 1'b0;
            region_o            <= 2'b00;
            region_valid_o      <= 1'b0;
            status_two_o        <= flash_suspend_pkg::STATUS_TWO_RESET;
        end else begin
            opcode_o            <= opcode_o_next;
            opcode_valid_o      <= opv_reg;
            opcode_accept_o     <= opv_reg && accept; // RULE8
            read_undetermined_o <= undet_next;
            region_o            <= region_next;
            region_valid_o      <= regv_next;
            status_two_o        <= stat_next;
        end
    end

    // device only listens in this block; outputs stay released
    assign link.io_dev_o  = 4'hF;
    assign link.io_dev_oe = 4'h0;
endmodule : flash_suspend_device

// File: logic/flash_suspend_host.sv
// host end: sends an opcode and optional 24-bit address over the link
module flash_suspend_host (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    flash_link_if.host       link,
    input  wire logic        quad_mode_i,
    input  wire logic        send_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic        with_addr_i,
    input  wire logic [23:0] addr_i,
    output logic             ready_o,
    output logic             done_o
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} host_state_e;
    host_state_e state_reg, state_next;
    logic [31:0] sh_reg, sh_next;
    logic [5:0]  left_reg, left_next;
    logic [3:0]  div_reg, div_next;
    logic        quad_reg, quad_next;
    logic        done_next;

    always_comb begin
        state_next = state_reg;
        sh_next    = sh_reg;
        left_next  = left_reg;
        quad_next  = quad_reg;
        div_next   = (div_reg != 4'd0) ? div_reg - 4'd1 : 4'd0;
        done_next  = 1'b0;
        case (state_reg)
            H_IDLE: if (send_i) begin
                // high byte of secure area address: host keeps bits 23..16 as given (RULE19 is caller's)
                sh_next    = {opcode_i, addr_i};
                left_next  = with_addr_i ? 6'd32 : 6'd8;
                quad_next  = quad_mode_i;
                div_next   = 4'(flash_suspend_pkg::LINK_HALF_CYCLES);
                state_next = H_LOW;
            end
            H_LOW: if (div_reg == 4'd0) begin
                div_next   = 4'(flash_suspend_pkg::LINK_HALF_CYCLES);
                state_next = H_HIGH;
            end
            H_HIGH: if (div_reg == 4'd0) begin
                div_next  = 4'(flash_suspend_pkg::LINK_HALF_CYCLES);
                if (quad_reg) begin
                    sh_next   = {sh_reg[27:0], 4'h0}; // RULE17
                    left_next = left_reg - 6'd4;
                end else begin
                    sh_next   = {sh_reg[30:0], 1'b0};
                    left_next = left_reg - 6'd1;
                end
                state_next = (left_next == 6'd0) ? H_END : H_LOW;
            end
            H_END: if (div_reg == 4'd0) begin
                done_next  = 1'b1;
                state_next = H_IDLE;
            end
            default: state_next = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= H_IDLE;
            sh_reg    <= 32'h0000_0000;
            left_reg  <= 6'd0;
            div_reg   <= 4'd0;
            quad_reg  <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            state_reg <= state_next;
            sh_reg    <= sh_next;
            left_reg  <= left_next;
            div_reg   <= div_next;
            quad_reg  <= quad_next;
            done_o    <= done_next;
        end
    end

    assign ready_o         = state_reg == H_IDLE;
    assign link.sel_n      = state_reg == H_IDLE;
    assign link.sclk       = state_reg == H_HIGH;
    assign link.io_host_o  = quad_reg ? sh_reg[31:28] : {3'b111, sh_reg[31]};
    assign link.io_host_oe = (state_reg == H_LOW || state_reg == H_HIGH) ? (quad_reg ? 4'hF : 4'h1) : 4'h0;
endmodule : flash_suspend_host

// File: verification/flash_suspend_sva.sv
// concurrent checks on the link and on device suspend status
module flash_suspend_sva (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       sel_n,
    input wire logic       sclk,
    input wire logic [3:0] io_dev_oe,
    input wire logic [7:0] opcode_o,
    input wire logic       opcode_valid_o,
    input wire logic       opcode_accept_o,
    input wire logic [7:0] status_two_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    wire susp = |status_two_o[1:0];
    wire take = opcode_valid_o && susp;
    sequence s_resume;
        take && opcode_accept_o && opcode_o == 8'h7A;
    endsequence
    sequence s_busy;
        ##[1:3] status_two_o[2];
    endsequence
    //==========================================================================
    // link and status
    a_dev_quiet: assert property (io_dev_oe == 4'h0) else $error("device drives io");
    a_sclk_idle: assert property (sel_n && $past(sel_n) |-> !sclk) else $error("sclk outside frame");
    a_flags_apart: assert property (!(status_two_o[0] && status_two_o[1])) else $error("two flags");
    a_prog_idle: assert property (status_two_o[0] |-> !status_two_o[2]) else $error("busy in suspend");
    a_list_taken: assert property (take && opcode_o inside {8'hE2, 8'h6B, 8'h6C, 8'hEB,
        8'hEC, 8'hED, 8'hFF, 8'h48, 8'h7A, 8'h66, 8'h99} |-> opcode_accept_o) else $error("listed opcode refused");
    a_write_refused: assert property (take && opcode_o inside {8'h01, 8'h71, 8'hFB} |-> !opcode_accept_o)
        else $error("write taken in suspend");
    a_secure_prog: assert property (take && status_two_o[0] && opcode_o == 8'h42 |-> !opcode_accept_o)
        else $error("secure program taken");
    a_resume_busy: assert property (s_resume |-> s_busy) else $error("resume left busy low");
    a_no_self_go: assert property ($fell(status_two_o[1]) |-> status_two_o[2]) else $error("self resume");
    a_idle_resume: assert property (opcode_valid_o && !susp && !status_two_o[2] && opcode_o == 8'h7A
        |=> $stable(status_two_o)[*3]) else $error("idle resume moved status");
endmodule : flash_suspend_sva

// File: verification/flash_suspend_resume_control_bench.sv
// self-checking bench: host and device ends joined over the link
module flash_suspend_resume_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, qm = 1'b0, ers = 1'b0, prg = 1'b0, sus = 1'b0, send = 1'b0, wa = 1'b0;
    logic [7:0] op = 8'h00, opc, st;
    logic [23:0] addr = 24'h000000;
    logic rdy, vld, acc, und, rv, dn, pg = 1'b0;
    logic [1:0] rgn;
    logic [7:0] ok [12] = '{8'hE2, 8'h6B, 8'h6C, 8'hEB, 8'hEC, 8'hED, 8'hFF, 8'h48, 8'h66, 8'h99, 8'h07, 8'h42};
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    flash_link_if flash_link_if_inst ();
    flash_suspend_host flash_suspend_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(flash_link_if_inst.host),
        .quad_mode_i(qm), .send_i(send), .opcode_i(op), .with_addr_i(wa), .addr_i(addr), .ready_o(rdy), .done_o(dn));
    flash_suspend_device #(.OP_CYCLES(64)) flash_suspend_device_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .link(flash_link_if_inst.dev), .quad_mode_i(qm), .start_erase_i(ers), .start_prog_i(prg), .suspend_i(sus),
        .busy_addr_i(24'h012345), .busy_is_page_i(pg), .opcode_o(opc), .opcode_valid_o(vld),
        .opcode_accept_o(acc), .read_undetermined_o(und), .region_o(rgn), .region_valid_o(rv), .status_two_o(st));
    flash_suspend_sva flash_suspend_sva_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_n(flash_link_if_inst.sel_n),
        .sclk(flash_link_if_inst.sclk), .io_dev_oe(flash_link_if_inst.io_dev_oe), .opcode_o(opc),
        .opcode_valid_o(vld), .opcode_accept_o(acc), .status_two_o(st));
    //==========================================================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    // one frame; the answer pulse is caught on the falling edge, where it is settled
    task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic w, input logic exp);
        op = o;
        addr = a;
        wa = w;
        pulse(send);
        for (int i = 0; i < 500 && !vld; i++) @(negedge sys_clk_i);
        chk({6'h00, vld, acc}, {6'h00, 1'b1, exp});
        chk(opc, o);
        for (int i = 0; i < 500 && !dn; i++) @(negedge sys_clk_i);
        chk({6'h00, dn, rdy}, 8'h03);
        tick(1);
    endtask : cmd
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end
    //==========================================================================
    // scenarios
    initial begin
        tick(16);
        rst_i = 1'b0;
        chk(st, 8'h00);
        cmd(8'h7A, 24'h0, 1'b0, 1'b1);
        chk(st, 8'h00);
        pulse(ers);
        tick(4);
        pulse(sus);
        tick(3);
        chk(st, 8'h02);
        for (int k = 0; k < 12; k++) begin
            qm = k[0];
            cmd(ok[k], 24'h0, 1'b0, 1'b1);
        end
        qm = 1'b0;
        cmd(8'h01, 24'h0, 1'b0, 1'b0);
        cmd(8'h71, 24'h0, 1'b0, 1'b0);
        cmd(8'hFB, 24'h0, 1'b0, 1'b0);
        chk(st, 8'h02);
        for (int r = 0; r < 4; r++) begin
            cmd(8'h48, {16'(r), 8'h5A}, 1'b1, 1'b1);
            chk({5'h00, rv, rgn}, {5'h00, 1'b1, 2'(r)});
        end
        cmd(8'h6B, 24'h012FFF, 1'b1, 1'b1);
        chk({7'h00, und}, 8'h01);
        cmd(8'h6B, 24'h013000, 1'b1, 1'b1);
        chk({7'h00, und}, 8'h00);
        pulse(prg);
        tick(2);
        chk(st, 8'h06);
        tick(70);
        chk(st, 8'h02);
        qm = 1'b1;
        cmd(8'h7A, 24'h0, 1'b0, 1'b1);
        qm = 1'b0;
        chk(st, 8'h04);
        tick(80);
        chk(st, 8'h00);
        pulse(prg);
        tick(4);
        pulse(sus);
        tick(3);
        chk(st, 8'h01);
        pg = 1'b1;
        cmd(8'h6B, 24'h012300, 1'b1, 1'b1);
        chk({7'h00, und}, 8'h01);
        cmd(8'h6B, 24'h012400, 1'b1, 1'b1);
        chk({7'h00, und}, 8'h00);
        cmd(8'h42, 24'h0, 1'b0, 1'b0);
        cmd(8'h7A, 24'h0, 1'b0, 1'b1);
        chk(st, 8'h04);
        tick(80);
        chk(st, 8'h00);
        conclude();
    end
endmodule : flash_suspend_resume_control_bench
